/* File: osdsp_dev.sv */
// device end: two-wire slave reaching a 16-bit internal address space
// assumes a memory side that answers a read strobe with data one cycle later
`timescale 1ns/1ps

// Function
// R1: answer only slave address 1011101
// R2: write is address, two pointer bytes, data
// R3: each write byte stored, pointer then increments
// R4: bytes msb first, writes end with stop
// R5: read sets pointer in a first sequence
// R6: read sequence returns consecutive bytes from pointer
// R7: rom never written, only ram and registers
// R8: reads reach ram, rom and registers
// R9: decode ram, rom, registers; rest empty
// R10: low byte at lower address
// R11: host writes descriptors low byte first
// R12: empty space acked, writes dropped, reads fixed
module osdsp_dev
  import osdsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link
  osdsp_if.dev bus,
  // internal write port
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  output osdsp_space_t wr_space,
  // internal read port
  output logic rd_en,
  output logic [15:0] rd_addr,
  output osdsp_space_t rd_space,
  input wire logic [7:0] rd_data
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    OSDSP_D_IDLE,
    OSDSP_D_RX,
    OSDSP_D_ACK,
    OSDSP_D_TX,
    OSDSP_D_RACK
  } osdsp_dstate_t;

  osdsp_dstate_t state;  // byte level state
  logic [1:0] scl_sync;  // clock synchroniser
  logic [1:0] sda_sync;  // data synchroniser
  logic scl_d;           // delayed synchronised clock
  logic sda_d;           // delayed synchronised data
  logic [3:0] cnt;       // bit count within a byte
  logic [7:0] rx_sh;     // incoming shift register
  logic [7:0] tx_sh;     // outgoing shift register
  logic [7:0] tx_byte;   // prefetched byte for the next read
  logic [1:0] phase;     // 0 slave, 1 pointer high, 2 pointer low, 3 data
  logic rw;              // current sequence is a read
  logic [15:0] ptr;      // internal address pointer
  logic pend;            // read data arrives this cycle
  logic sda_low;         // device pulls data low

  // ==========================================================================
  // synchronisers and line events
  // ==========================================================================
  // both lines take the same delay so start and stop keep their order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  wire scl_s = scl_sync[1];   // clean clock level
  wire sda_s = sda_sync[1];   // clean data level
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // data moving while the clock is high marks frame edges
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_end = scl_fall & (cnt == 4'h8);

  // ==========================================================================
  // address decode
  // ==========================================================================
  wire addr_hit = (rx_sh[7:1] == OSDSP_SLAVE_ADDR); // R1
  wire in_ram = (ptr <= OSDSP_RAM_HI); // R9
  wire in_rom = (ptr >= OSDSP_ROM_LO) & (ptr <= OSDSP_ROM_HI); // R9
  wire in_reg = (ptr >= OSDSP_REG_LO) & (ptr <= OSDSP_REG_HI); // R9
  wire osdsp_space_t ptr_space = in_ram ? OSDSP_SP_RAM :
                                 in_rom ? OSDSP_SP_ROM :
                                 in_reg ? OSDSP_SP_REG : OSDSP_SP_NONE;
  // rom is read-only from the link; empty space swallows writes
  wire writable = in_ram | in_reg; // R7 R12
  wire readable = in_ram | in_rom | in_reg; // R8

  // ==========================================================================
  // link outputs
  // ==========================================================================
  // open drain: only ever a low level
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_low;

  // ==========================================================================
  // byte level state machine
  // ==========================================================================
  // start and stop override anything in flight, so a host abort always recovers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= OSDSP_D_IDLE;
      cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      tx_byte <= OSDSP_FILL;
      phase <= 2'h0;
      rw <= 1'b0;
      ptr <= 16'h0000;
      pend <= 1'b0;
      sda_low <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 8'h00;
      wr_space <= OSDSP_SP_NONE;
      rd_en <= 1'b0;
      rd_addr <= 16'h0000;
      rd_space <= OSDSP_SP_NONE;
    end else begin
      // strobes are single cycle
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      pend <= rd_en;
      // prefetched byte lands; pointer steps past it
      if (pend) begin
        tx_byte <= (rd_space == OSDSP_SP_NONE) ? OSDSP_FILL : rd_data; // R12
        ptr <= ptr + 16'h0001; // R6
      end
      if (start_det) begin
        // first byte after any start is the slave address
        state <= OSDSP_D_RX;
        cnt <= 4'h0;
        phase <= 2'h0;
        sda_low <= 1'b0;
      end else if (stop_det) begin
        // pointer survives the stop so a read can follow
        state <= OSDSP_D_IDLE; // R4
        sda_low <= 1'b0;
      end else begin
        case (state)
          OSDSP_D_IDLE: begin
            // not addressed: wait for the next start
            sda_low <= 1'b0;
          end
          OSDSP_D_RX: begin
            if (scl_rise) begin
              // first bit in is the most significant
              rx_sh <= {rx_sh[6:0], sda_s}; // R4
              cnt <= cnt + 4'h1;
            end else if (byte_end) begin
              cnt <= 4'h0;
              if (phase == 2'h0) begin
                if (addr_hit) begin
                  rw <= rx_sh[OSDSP_RW_BIT];
                  sda_low <= 1'b1; // R1
                  state <= OSDSP_D_ACK;
                  phase <= 2'h1; // R2
                  if (rx_sh[OSDSP_RW_BIT]) begin
                    // fetch the first read byte from the stored pointer
                    rd_en <= 1'b1; // R6
                    rd_addr <= ptr;
                    rd_space <= readable ? ptr_space : OSDSP_SP_NONE; // R8
                  end
                end else begin
                  // someone else's address: stay off the wire
                  state <= OSDSP_D_IDLE;
                end
              end else begin
                // every byte is acked, empty space included
                sda_low <= 1'b1; // R12
                state <= OSDSP_D_ACK;
                if (phase == 2'h1) begin
                  ptr[15:8] <= rx_sh; // R5
                  phase <= 2'h2;
                end else if (phase == 2'h2) begin
                  ptr[7:0] <= rx_sh; // R5
                  phase <= 2'h3;
                end else begin
                  // data byte: store at pointer, then step
                  wr_en <= writable; // R3 R7 R12
                  wr_addr <= ptr;
                  wr_data <= rx_sh;
                  wr_space <= ptr_space;
                  ptr <= ptr + 16'h0001; // R3 R10
                end
              end
            end
          end
          OSDSP_D_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                // first read bit goes out as the ack clock ends
                state <= OSDSP_D_TX;
                tx_sh <= tx_byte;
                sda_low <= ~tx_byte[7]; // R4 R6
              end else begin
                state <= OSDSP_D_RX;
                sda_low <= 1'b0;
              end
            end
          end
          OSDSP_D_TX: begin
            if (scl_fall) begin
              if (cnt == 4'h7) begin
                // release for the host's acknowledge
                state <= OSDSP_D_RACK;
                sda_low <= 1'b0;
              end else begin
                tx_sh <= {tx_sh[6:0], 1'b0};
                sda_low <= ~tx_sh[6]; // R4
                cnt <= cnt + 4'h1;
              end
            end
          end
          OSDSP_D_RACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                // host declined more: let go until stop or start
                state <= OSDSP_D_IDLE;
              end else begin
                // host wants more: fetch the next address
                rd_en <= 1'b1; // R6
                rd_addr <= ptr;
                rd_space <= readable ? ptr_space : OSDSP_SP_NONE;
              end
            end else if (scl_fall) begin
              state <= OSDSP_D_TX;
              cnt <= 4'h0;
              tx_sh <= tx_byte;
              sda_low <= ~tx_byte[7]; // R6
            end
          end
          default: begin
            state <= OSDSP_D_IDLE;
            sda_low <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* File: osdsp_host.sv */
// host end: two-wire master that writes or reads the device's internal space
// assumes no clock stretching by the device and a single master on the wire
`timescale 1ns/1ps
module osdsp_host
  import osdsp_pkg::*;
#(
  parameter int QTR = OSDSP_QTR_CYCLES // system clocks per quarter bit
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link
  osdsp_if.host bus,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_count,
  output logic cmd_ready,
  // write data stream
  input wire logic [7:0] wdata,
  input wire logic wdata_valid,
  output logic wdata_ready,
  // read data and completion
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic done,
  output logic nack
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    OSDSP_H_IDLE,
    OSDSP_H_START,
    OSDSP_H_BYTE,
    OSDSP_H_WAIT,
    OSDSP_H_STOP
  } osdsp_hstate_t;

  typedef enum logic [2:0] {
    OSDSP_G_SLW,
    OSDSP_G_AHI,
    OSDSP_G_ALO,
    OSDSP_G_WDATA,
    OSDSP_G_SLR,
    OSDSP_G_RDATA
  } osdsp_stage_t;

  osdsp_hstate_t state; // bit level state
  osdsp_stage_t stage;  // which byte of the frame
  logic [1:0] sda_sync; // data synchroniser
  logic [15:0] qcnt;    // quarter timer
  logic [1:0] q;        // quarter within a bit
  logic [3:0] bi;       // bit within a byte, 8 is acknowledge
  logic [7:0] sh;       // shift register, out and in
  logic rd_byte;        // current byte is read from the device
  logic ack_in;         // acknowledge level seen
  logic rd_req;         // command is a read
  logic [15:0] addr;    // latched pointer
  logic [7:0] remain;   // data bytes left
  logic scl_low;        // host pulls clock low
  logic sda_low;        // host pulls data low

  wire sda_s = sda_sync[1];
  wire tick = (state != OSDSP_H_IDLE) & (state != OSDSP_H_WAIT) &
              (qcnt == 16'(QTR - 1));
  wire last = (remain == 8'h01);
  wire take = (state == OSDSP_H_WAIT) & wdata_valid;

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_low;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_low;
  assign cmd_ready = (state == OSDSP_H_IDLE);
  assign wdata_ready = (state == OSDSP_H_WAIT);

  // ==========================================================================
  // data synchroniser and quarter timer
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_sync <= 2'h3;
      qcnt <= 16'h0000;
    end else begin
      sda_sync <= {sda_sync[0], bus.sda};
      qcnt <= (tick | ~(state inside {OSDSP_H_START, OSDSP_H_BYTE, OSDSP_H_STOP})) ?
              16'h0000 : qcnt + 16'h0001;
    end
  end

  // ==========================================================================
  // frame sequencer
  // ==========================================================================
  // quarters: 0 clock low, 1 clock high then sample, 2 clock falls, 3 clock low then advance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= OSDSP_H_IDLE;
      stage <= OSDSP_G_SLW;
      q <= 2'h0;
      bi <= 4'h0;
      sh <= 8'h00;
      rd_byte <= 1'b0;
      ack_in <= 1'b0;
      rd_req <= 1'b0;
      addr <= 16'h0000;
      remain <= 8'h00;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      rdata_valid <= 1'b0;
      done <= 1'b0;
      if (tick) begin
        q <= q + 2'h1;
      end
      case (state)
        OSDSP_H_IDLE: begin
          if (cmd_valid) begin
            // frame opens with slave address, write flag low
            state <= OSDSP_H_START; // R2 R5
            stage <= OSDSP_G_SLW;
            q <= 2'h0;
            rd_req <= cmd_read;
            addr <= cmd_addr;
            remain <= cmd_count;
            nack <= 1'b0;
          end
        end
        OSDSP_H_START: begin
          // release data, raise clock, pull data low, pull clock low
          if (tick & (q == 2'h0)) scl_low <= 1'b0;
          if (tick & (q == 2'h1)) sda_low <= 1'b1;
          if (tick & (q == 2'h2)) scl_low <= 1'b1;
          if (tick & (q == 2'h3)) begin
            state <= OSDSP_H_BYTE;
            bi <= 4'h0;
            rd_byte <= 1'b0;
            sh <= {OSDSP_SLAVE_ADDR, stage == OSDSP_G_SLR};
            sda_low <= ~OSDSP_SLAVE_ADDR[6];
          end else if (q == 2'h0) begin
            sda_low <= 1'b0;
          end
        end
        OSDSP_H_BYTE: begin
          if (tick & (q == 2'h0)) scl_low <= 1'b0;
          if (tick & (q == 2'h1)) begin
            if (bi == 4'h8) ack_in <= sda_s;
            else sh <= {sh[6:0], sda_s};
          end
          if (tick & (q == 2'h2)) scl_low <= 1'b1;
          if (tick & (q == 2'h3)) begin
            if (bi != 4'h8) begin
              bi <= bi + 4'h1;
              // shifted value puts the next bit on top, msb first
              if (bi == 4'h7) sda_low <= rd_byte & ~last; // R4
              else sda_low <= ~rd_byte & ~sh[7]; // R4
            end else if (~rd_byte & ack_in) begin
              nack <= 1'b1;
              state <= OSDSP_H_STOP;
              sda_low <= 1'b1;
            end else begin
              case (stage)
                OSDSP_G_SLW: begin
                  stage <= OSDSP_G_AHI;
                  bi <= 4'h0;
                  sh <= addr[15:8];
                  sda_low <= ~addr[15];
                end
                OSDSP_G_AHI: begin
                  stage <= OSDSP_G_ALO;
                  bi <= 4'h0;
                  sh <= addr[7:0];
                  sda_low <= ~addr[7];
                end
                OSDSP_G_ALO: begin
                  // a read ends its pointer sequence and opens a second one
                  stage <= rd_req ? OSDSP_G_SLR : OSDSP_G_WDATA; // R5
                  state <= rd_req ? OSDSP_H_START : OSDSP_H_WAIT;
                  sda_low <= 1'b0;
                end
                OSDSP_G_WDATA: begin
                  remain <= remain - 8'h01;
                  state <= last ? OSDSP_H_STOP : OSDSP_H_WAIT; // R4
                  sda_low <= last;
                end
                OSDSP_G_SLR: begin
                  stage <= OSDSP_G_RDATA;
                  bi <= 4'h0;
                  rd_byte <= 1'b1;
                  sda_low <= 1'b0;
                end
                default: begin
                  // read byte complete; last one was refused with a high ack
                  rdata <= sh;
                  rdata_valid <= 1'b1;
                  remain <= remain - 8'h01;
                  bi <= 4'h0;
                  state <= last ? OSDSP_H_STOP : OSDSP_H_BYTE;
                  sda_low <= last;
                end
              endcase
            end
          end
        end
        OSDSP_H_WAIT: begin
          // clock held low while the stream has nothing; bytes go in given order
          if (take) begin
            state <= OSDSP_H_BYTE; // R11
            q <= 2'h0;
            bi <= 4'h0;
            sh <= wdata;
            sda_low <= ~wdata[7];
          end
        end
        OSDSP_H_STOP: begin
          // data low, clock high, data rises
          if (tick & (q == 2'h0)) scl_low <= 1'b0;
          if (tick & (q == 2'h1)) sda_low <= 1'b0; // R4
          if (tick & (q == 2'h3)) begin
            state <= OSDSP_H_IDLE;
            done <= 1'b1;
          end
        end
        default: begin
          state <= OSDSP_H_IDLE;
          scl_low <= 1'b0;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: osdsp_if.sv */
// open-drain two-wire link joining the host end and the device end
// assumes each party only pulls low; released lines float high
`timescale 1ns/1ps
interface osdsp_if;

  // ==========================================================================
  // party drives
  // ==========================================================================
  logic host_scl_o;  // host clock level when enabled
  logic host_scl_oe; // host drives clock
  logic host_sda_o;  // host data level when enabled
  logic host_sda_oe; // host drives data
  logic dev_sda_o;   // device data level when enabled
  logic dev_sda_oe;  // device drives data

  // ==========================================================================
  // resolved wire levels
  // ==========================================================================
  logic scl;
  logic sda;

  // wired-and: a driven low wins, otherwise the pull-up
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );

endinterface

/* File: osdsp_note_end.sv */
// holds no logic: both ends and their checks live in their own files
// assumes nothing of its surroundings

/* File: osdsp_pkg.sv */
// constants shared by both ends of the osd serial host port
// assumes a 40 mhz system clock on both ends and a host-driven serial clock
package osdsp_pkg;

  // ==========================================================================
  // link addressing
  // ==========================================================================
  localparam logic [6:0] OSDSP_SLAVE_ADDR = 7'h5D; // seven address bits 1011101
  localparam int OSDSP_RW_BIT = 0;                 // read/write flag position
  localparam logic [7:0] OSDSP_FILL = 8'hFF;       // read value of empty space

  // ==========================================================================
  // internal address map
  // ==========================================================================
  localparam logic [15:0] OSDSP_RAM_HI = 16'h03FF; // text and descriptor ram top
  localparam logic [15:0] OSDSP_ROM_LO = 16'h0800; // character rom base
  localparam logic [15:0] OSDSP_ROM_HI = 16'h3FFF; // character rom top
  localparam logic [15:0] OSDSP_REG_LO = 16'h4000; // register block base
  localparam logic [15:0] OSDSP_REG_HI = 16'h403F; // register block top

  // target of an internal access
  typedef enum logic [1:0] {
    OSDSP_SP_NONE,
    OSDSP_SP_RAM,
    OSDSP_SP_ROM,
    OSDSP_SP_REG
  } osdsp_space_t;

  // ==========================================================================
  // host timing
  // ==========================================================================
  localparam int OSDSP_CLK_PERIOD_NS = 25; // system clock period
  localparam int OSDSP_SCL_QTR_NS = 625;   // quarter of a 400 khz serial clock
  // least time, so round up
  localparam int OSDSP_QTR_CYCLES =
    (OSDSP_SCL_QTR_NS + OSDSP_CLK_PERIOD_NS - 1) / OSDSP_CLK_PERIOD_NS;

endpackage

/* File: osdsp_props.sv */
// wire-level checks on the two-wire link joining host end and device end
// assumes the host runs a quarter bit of at least four system clocks
`timescale 1ns/1ps
module osdsp_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // party drives
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // framing events
  // ==========================================================================
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  // ==========================================================================
  // properties
  // ==========================================================================
  // open drain: a driven high would fight the pull-up
  property p_dev_pull;
    dev_sda_oe |-> !dev_sda_o;
  endproperty
  property p_host_pull;
    !(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o);
  endproperty
  // device data moves only while the clock is low
  property p_dev_chg_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_dev_hold_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  // a byte plus ack is the longest the device may hold the line
  property p_dev_release;
    $rose(dev_sda_oe) |-> ##[1:200] !dev_sda_oe;
  endproperty
  // device stays off the line for eight clocks once a frame is closed
  property p_stop_idle;
    s_stop |-> !dev_sda_oe [*8];
  endproperty
  property p_scl_high_min;
    $rose(scl) |-> scl [*4];
  endproperty
  property p_start_hold;
    s_start |-> scl [*3];
  endproperty

  a_dev_pull: assert property (p_dev_pull) else $error("device drove data high");
  a_host_pull: assert property (p_host_pull) else $error("host drove a line high");
  a_dev_chg_low: assert property (p_dev_chg_low) else $error("device data moved with clock high");
  a_dev_hold_high: assert property (p_dev_hold_high) else $error("device data unstable");
  a_dev_release: assert property (p_dev_release) else $error("device held data too long");
  a_stop_idle: assert property (p_stop_idle) else $error("device drove after stop");
  a_scl_high_min: assert property (p_scl_high_min) else $error("clock high too short");
  a_start_hold: assert property (p_start_hold) else $error("start not held");
endmodule

/* File: test_osd_serial_host_port.sv */
// self-checking bench: host end and device end joined on one link
// assumes a memory model on the device's internal port answering next cycle
`timescale 1ns/1ps
module test_osd_serial_host_port
  import osdsp_pkg::*;
;
  // ==========================================================================
  // signals and models
  // ==========================================================================
  logic clk, rst_b, cmd_valid, cmd_read, cmd_ready, wdata_valid, wdata_ready;
  logic rdata_valid, done, nack, wr_en, rd_en;
  logic [15:0] cmd_addr, wr_addr, rd_addr;
  logic [7:0] cmd_count, wdata, rdata, wr_data, rd_data;
  osdsp_space_t wr_space, rd_space;
  logic [7:0] mem [0:65535]; // device memory model
  logic [7:0] shadow [0:65535]; // expected contents
  logic [25:0] wq [$]; // expected write strobes
  logic [7:0] rq [$]; // expected read bytes
  int error_cnt, checked, cyc;
  // boundary starts: ram top, empty/rom edge, register top, 16-bit pair, rom/reg, wrap
  logic [15:0] ta [6] = '{16'h03FE, 16'h07FF, 16'h403F, 16'h4000, 16'h3FFF, 16'hFFFF};
  int tn [6] = '{4, 2, 2, 2, 2, 2};

  osdsp_if bus ();
  osdsp_host #(.QTR(4)) osdsp_host_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
    .cmd_ready(cmd_ready), .wdata(wdata), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready),
    .rdata(rdata), .rdata_valid(rdata_valid), .done(done), .nack(nack));
  osdsp_dev osdsp_dev_inst (.clk(clk), .rst_b(rst_b), .bus(bus), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_space(wr_space), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_space(rd_space), .rd_data(rd_data));
  osdsp_props osdsp_props_inst (.clk(clk), .rst_b(rst_b), .scl(bus.scl), .sda(bus.sda),
    .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));

  // expected target of an internal address
  function automatic osdsp_space_t sp(input logic [15:0] a);
    return a <= 16'h03FF ? OSDSP_SP_RAM : (a >= 16'h0800 && a <= 16'h3FFF) ? OSDSP_SP_ROM :
      (a >= 16'h4000 && a <= 16'h403F) ? OSDSP_SP_REG : OSDSP_SP_NONE;
  endfunction

  // ==========================================================================
  // comparison and closing
  // ==========================================================================
  task automatic cmp(input string what, input logic [25:0] e, input logic [25:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic chk_wr(input logic [25:0] g);
    cmp("write port", wq.size() ? wq.pop_front() : 'x, g);
  endtask
  task automatic chk_rd(input logic [7:0] g);
    cmp("read byte", rq.size() ? {18'h0_0000, rq.pop_front()} : 'x, {18'h0_0000, g});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one host command; write bytes random, expectations noted before they show
  task automatic xfer(input logic rd, input logic [15:0] a, input int n);
    @(negedge clk);
    cmd_valid = 1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_count = n[7:0];
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    cmd_valid = 0;
    for (int i = 0; i < n; i++) begin
      logic [15:0] p;
      p = a + i[15:0];
      if (rd) rq.push_back(sp(p) == OSDSP_SP_NONE ? OSDSP_FILL : shadow[p]);
      else begin
        wdata = 8'($urandom);
        wdata_valid = 1;
        // rom and empty space must never strobe
        if (sp(p) inside {OSDSP_SP_RAM, OSDSP_SP_REG}) begin
          wq.push_back({sp(p), p, wdata});
          shadow[p] = wdata;
        end
        @(posedge clk);
        while (wdata_ready !== 1'b1) @(posedge clk);
        @(negedge clk);
      end
    end
    wdata_valid = 0;
    @(posedge clk);
    while (done !== 1'b1) @(posedge clk);
    cmp("nack", 26'h0, {25'h0, nack});
  endtask

  // ==========================================================================
  // clock, models, watcher
  // ==========================================================================
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // internal memory: data ready one cycle after the fetch strobe
  always @(negedge clk) begin
    if (wr_en === 1'b1) mem[wr_addr] = wr_data;
    if (rd_en === 1'b1) rd_data = mem[rd_addr];
  end
  always @(negedge clk) begin
    if (wr_en === 1'b1) chk_wr({wr_space, wr_addr, wr_data});
    if (rdata_valid === 1'b1) chk_rd(rdata);
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {rst_b, cmd_valid, cmd_read, wdata_valid, cmd_addr, cmd_count, wdata} = '0;
    rd_data = 8'hFF;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8];
      shadow[i] = mem[i];
    end
    void'($urandom(63732));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_b = 1;
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, ta[k], tn[k]);
      xfer(1'b1, ta[k], tn[k]);
      $display("test %0d done", k);
    end
    conclude();
  end
endmodule
